/* filt_setup_map.vh */
// Register map, field positions, reset values and decode codes of the
// per-setup filter configuration bank.
// Assumes a 32-bit AXI4-Lite slave with one aligned word per register.
`ifndef FILT_SETUP_MAP_VH
`define FILT_SETUP_MAP_VH

// ----------------------------------------------------------------------
// Register indices and byte addresses
// ----------------------------------------------------------------------
`define FCFG_IDX_S1        8'h29
`define FCFG_IDX_S2        8'h2a
`define FCFG_ADDR_S1       10'h0a4
`define FCFG_ADDR_S2       10'h0a8
`define FCFG_RESET         16'h0000

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define FCFG_MAP_BIT       15
`define FCFG_EN_BIT        11
`define FCFG_SEL_HI        10
`define FCFG_SEL_LO        8
`define FCFG_TYPE_HI       6
`define FCFG_TYPE_LO       5
`define FCFG_RATE_HI       4
`define FCFG_RATE_LO       0
`define FCFG_WR_MASK       16'h8f7f

// ----------------------------------------------------------------------
// Codes
// ----------------------------------------------------------------------
`define FTYPE_SINC5_SINC1  2'h0
`define FTYPE_SINC3        2'h3
`define PSEL_27SPS         3'h2
`define PSEL_25SPS         3'h3
`define PSEL_20SPS         3'h5
`define PSEL_16SPS         3'h6
`define DECIM_PRESCALE     6'h20
`define RATE_CODE_MAX      5'h14
`define AXI_OKAY           2'h0
`define AXI_SLVERR         2'h2

`endif

/* adc_filter_setup_config_regs.v */
// Filter configuration registers for setups 1 and 2, with decode of each
// setup into the controls the filter datapath consumes.
// Assumes an AXI4-Lite master on sys_clk_i and a datapath on the same clock.
`timescale 1ns/1ps
`include "filt_setup_map.vh"

module adc_filter_setup_config_regs
#(
  parameter ADDR_W = 10
)
(
  // Clock and reset
  input  wire              sys_clk_i,
  input  wire              nrst_i,
  // AXI4-Lite write address and data
  input  wire [ADDR_W-1:0] s_axi_awaddr_i,
  input  wire              s_axi_awvalid_i,
  output wire              s_axi_awready_o,
  input  wire [31:0]       s_axi_wdata_i,
  input  wire [3:0]        s_axi_wstrb_i,
  input  wire              s_axi_wvalid_i,
  output wire              s_axi_wready_o,
  // AXI4-Lite write response
  output wire [1:0]        s_axi_bresp_o,
  output wire              s_axi_bvalid_o,
  input  wire              s_axi_bready_i,
  // AXI4-Lite read
  input  wire [ADDR_W-1:0] s_axi_araddr_i,
  input  wire              s_axi_arvalid_i,
  output wire              s_axi_arready_o,
  output wire [31:0]       s_axi_rdata_o,
  output wire [1:0]        s_axi_rresp_o,
  output wire              s_axi_rvalid_o,
  input  wire              s_axi_rready_i,
  // Setup 1 controls to the filter datapath
  output wire              direct_decim_mode_s1_o,
  output wire [14:0]       direct_decim_value_s1_o,
  output wire [20:0]       decim_total_s1_o,
  output wire [1:0]        filter_type_s1_o,
  output wire              post_rejection_on_s1_o,
  output wire [2:0]        post_rejection_sel_s1_o,
  output wire              post_sel_valid_s1_o,
  output wire [4:0]        sample_rate_code_s1_o,
  output wire              rate_code_valid_s1_o,
  // Setup 2 controls to the filter datapath
  output wire              direct_decim_mode_s2_o,
  output wire [14:0]       direct_decim_value_s2_o,
  output wire [20:0]       decim_total_s2_o,
  output wire [1:0]        filter_type_s2_o,
  output wire              post_rejection_on_s2_o,
  output wire [2:0]        post_rejection_sel_s2_o,
  output wire              post_sel_valid_s2_o,
  output wire [4:0]        sample_rate_code_s2_o,
  output wire              rate_code_valid_s2_o
);

  // ----------------------------------------------------------------------
  // Bus handshake state
  // ----------------------------------------------------------------------
  reg              aw_held_ff;
  reg [ADDR_W-1:0] aw_addr_ff;
  reg              w_held_ff;
  reg [31:0]       w_data_ff;
  reg [3:0]        w_strb_ff;
  reg              bvalid_ff;
  reg [1:0]        bresp_ff;
  reg              rvalid_ff;
  reg [1:0]        rresp_ff;
  reg [31:0]       rdata_ff;
  reg              awready_ff;
  reg              wready_ff;
  reg              arready_ff;

  // Stored register images, one per setup
  reg [15:0]       cfg_s1_ff;
  reg [15:0]       cfg_s2_ff;

  wire             aw_take;
  wire             w_take;
  wire             wr_fire;
  wire             ar_take;
  wire [15:0]      wr_merged_s1;
  wire [15:0]      wr_merged_s2;
  wire [15:0]      wr_raw_s1;
  wire [15:0]      wr_raw_s2;
  wire             nxt_aw_held;
  wire             nxt_w_held;
  wire             nxt_bvalid;
  wire             nxt_rvalid;
  wire             wr_hit_s1;
  wire             wr_hit_s2;

  // Each ready only while its own half is not held and no response on its channel is pending; the
  // readies are registered from the next handshake state to leave a flop
  assign s_axi_awready_o = awready_ff;
  assign s_axi_wready_o  = wready_ff;
  assign s_axi_arready_o = arready_ff;

  assign aw_take = s_axi_awvalid_i & s_axi_awready_o;
  assign w_take  = s_axi_wvalid_i & s_axi_wready_o;
  assign ar_take = s_axi_arvalid_i & s_axi_arready_o;
  // Commit once both halves sit in the holding registers
  assign wr_fire = aw_held_ff & w_held_ff & ~bvalid_ff;
  // A half cannot be taken while held, so take and commit never collide
  assign nxt_aw_held = (aw_held_ff | aw_take) & ~wr_fire;
  assign nxt_w_held  = (w_held_ff | w_take) & ~wr_fire;
  assign nxt_bvalid  = wr_fire | (bvalid_ff & ~s_axi_bready_i);
  assign nxt_rvalid  = ar_take | (rvalid_ff & ~s_axi_rready_i);

  // Ready flops rise in the same cycle as the state that frees them
  always @(posedge sys_clk_i)
  begin
    if (!nrst_i)
    begin
      awready_ff <= 1'b1;
      wready_ff  <= 1'b1;
      arready_ff <= 1'b1;
    end
    else
    begin
      awready_ff <= ~nxt_aw_held & ~nxt_bvalid;
      wready_ff  <= ~nxt_w_held & ~nxt_bvalid;
      arready_ff <= ~nxt_rvalid;
    end
  end

  // Word-aligned decode; low address bits are ignored
  assign wr_hit_s1 = (aw_addr_ff[ADDR_W-1:2] == `FCFG_IDX_S1);
  assign wr_hit_s2 = (aw_addr_ff[ADDR_W-1:2] == `FCFG_IDX_S2);

  // ----------------------------------------------------------------------
  // Byte-lane merge
  // ----------------------------------------------------------------------
  // Only lanes 0 and 1 exist; upper lanes are dropped
  assign wr_raw_s1 = {w_strb_ff[1] ? w_data_ff[15:8] : cfg_s1_ff[15:8],
                      w_strb_ff[0] ? w_data_ff[7:0]  : cfg_s1_ff[7:0]};
  assign wr_raw_s2 = {w_strb_ff[1] ? w_data_ff[15:8] : cfg_s2_ff[15:8],
                      w_strb_ff[0] ? w_data_ff[7:0]  : cfg_s2_ff[7:0]};

  // Reserved bits forced to zero; map mode claims all fifteen low bits
  // as the decimation value, so the mask is skipped while it is set
  assign wr_merged_s1 = wr_raw_s1[`FCFG_MAP_BIT] ? wr_raw_s1 :
                        (wr_raw_s1 & `FCFG_WR_MASK);
  assign wr_merged_s2 = wr_raw_s2[`FCFG_MAP_BIT] ? wr_raw_s2 :
                        (wr_raw_s2 & `FCFG_WR_MASK);

  // ----------------------------------------------------------------------
  // Write channel and register storage
  // ----------------------------------------------------------------------
  // Address and data may arrive in either order
  always @(posedge sys_clk_i)
  begin
    if (!nrst_i)
    begin
      aw_held_ff <= 1'b0;
      aw_addr_ff <= {ADDR_W{1'b0}};
      w_held_ff  <= 1'b0;
      w_data_ff  <= 32'h00000000;
      w_strb_ff  <= 4'h0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= `AXI_OKAY;
      cfg_s1_ff  <= `FCFG_RESET;
      cfg_s2_ff  <= `FCFG_RESET;
    end
    else
    begin
      if (aw_take)
      begin
        aw_held_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr_i;
      end
      if (w_take)
      begin
        w_held_ff <= 1'b1;
        w_data_ff <= s_axi_wdata_i;
        w_strb_ff <= s_axi_wstrb_i;
      end
      if (wr_fire)
      begin
        aw_held_ff <= 1'b0;
        w_held_ff  <= 1'b0;
        bvalid_ff  <= 1'b1;
        // Independent storage per setup
        if (wr_hit_s1)
        begin
          cfg_s1_ff <= wr_merged_s1;
          bresp_ff  <= `AXI_OKAY;
        end
        else if (wr_hit_s2)
        begin
          cfg_s2_ff <= wr_merged_s2;
          bresp_ff  <= `AXI_OKAY;
        end
        else
        begin
          bresp_ff <= `AXI_SLVERR;
        end
      end
      else if (bvalid_ff && s_axi_bready_i)
      begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid_o = bvalid_ff;
  assign s_axi_bresp_o  = bresp_ff;

  // ----------------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------------
  // One-cycle read latency; unmapped reads give zero with SLVERR
  always @(posedge sys_clk_i)
  begin
    if (!nrst_i)
    begin
      rvalid_ff <= 1'b0;
      rresp_ff  <= `AXI_OKAY;
      rdata_ff  <= 32'h00000000;
    end
    else if (ar_take)
    begin
      rvalid_ff <= 1'b1;
      if (s_axi_araddr_i[ADDR_W-1:2] == `FCFG_IDX_S1)
      begin
        rdata_ff <= {16'h0000, cfg_s1_ff};
        rresp_ff <= `AXI_OKAY;
      end
      else if (s_axi_araddr_i[ADDR_W-1:2] == `FCFG_IDX_S2)
      begin
        rdata_ff <= {16'h0000, cfg_s2_ff};
        rresp_ff <= `AXI_OKAY;
      end
      else
      begin
        rdata_ff <= 32'h00000000;
        rresp_ff <= `AXI_SLVERR;
      end
    end
    else if (rvalid_ff && s_axi_rready_i)
    begin
      rvalid_ff <= 1'b0;
    end
  end

  assign s_axi_rvalid_o = rvalid_ff;
  assign s_axi_rresp_o  = rresp_ff;
  assign s_axi_rdata_o  = rdata_ff;

  // ----------------------------------------------------------------------
  // Per-setup decode to the datapath
  // ----------------------------------------------------------------------
  // Registered so each output leaves a flip-flop; one cycle behind storage
  reg [15:0] dec_img [0:1];

  always @*
  begin
    dec_img[0] = cfg_s1_ff;
    dec_img[1] = cfg_s2_ff;
  end

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_setup
      wire        map_on;
      wire [2:0]  psel;
      wire [1:0]  ftype;
      wire        psel_ok;
      reg         ctl_map_ff;
      reg  [14:0] ctl_decim_ff;
      reg  [20:0] ctl_total_ff;
      reg  [1:0]  ctl_type_ff;
      reg         ctl_pon_ff;
      reg  [2:0]  ctl_psel_ff;
      reg         ctl_pval_ff;
      reg  [4:0]  ctl_rate_ff;
      reg         ctl_rval_ff;

      assign map_on = dec_img[g][`FCFG_MAP_BIT];
      assign psel   = dec_img[g][`FCFG_SEL_HI:`FCFG_SEL_LO];
      assign ftype  = dec_img[g][`FCFG_TYPE_HI:`FCFG_TYPE_LO];
      // Only four post-select codes are defined; others treated as off
      assign psel_ok = (psel == `PSEL_27SPS) | (psel == `PSEL_25SPS) |
                       (psel == `PSEL_20SPS) | (psel == `PSEL_16SPS);

      always @(posedge sys_clk_i)
      begin
        if (!nrst_i)
        begin
          ctl_map_ff   <= 1'b0;
          ctl_decim_ff <= 15'h0000;
          ctl_total_ff <= 21'h000000;
          ctl_type_ff  <= `FTYPE_SINC5_SINC1;
          ctl_pon_ff   <= 1'b0;
          ctl_psel_ff  <= 3'h0;
          ctl_pval_ff  <= 1'b0;
          ctl_rate_ff  <= 5'h00;
          ctl_rval_ff  <= 1'b1;
        end
        else
        begin
          ctl_map_ff   <= map_on;
          // Low fifteen bits become the decimation value in map mode
          ctl_decim_ff <= map_on ? dec_img[g][14:0] : 15'h0000;
          // Total divide of the modulator clock for one channel
          ctl_total_ff <= map_on ?
            {1'b0, dec_img[g][14:0], 5'h00} : 21'h000000;
          // Map mode forces sinc3 and kills every other option
          ctl_type_ff  <= map_on ? `FTYPE_SINC3 : ftype;
          // Post filter only rides on the sinc5+sinc1 path
          ctl_pon_ff   <= ~map_on & dec_img[g][`FCFG_EN_BIT] &
                          (ftype == `FTYPE_SINC5_SINC1) & psel_ok;
          ctl_psel_ff  <= map_on ? 3'h0 : psel;
          // Select field means nothing in map mode, so no valid code then
          ctl_pval_ff  <= ~map_on & psel_ok;
          ctl_rate_ff  <= map_on ? 5'h00 :
                          dec_img[g][`FCFG_RATE_HI:`FCFG_RATE_LO];
          // Codes past the slowest table entry are flagged
          ctl_rval_ff  <= map_on |
            (dec_img[g][`FCFG_RATE_HI:`FCFG_RATE_LO] <= `RATE_CODE_MAX);
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Output wiring
  // ----------------------------------------------------------------------
  assign direct_decim_mode_s1_o  = g_setup[0].ctl_map_ff;
  assign direct_decim_value_s1_o = g_setup[0].ctl_decim_ff;
  assign decim_total_s1_o        = g_setup[0].ctl_total_ff;
  assign filter_type_s1_o        = g_setup[0].ctl_type_ff;
  assign post_rejection_on_s1_o  = g_setup[0].ctl_pon_ff;
  assign post_rejection_sel_s1_o = g_setup[0].ctl_psel_ff;
  assign post_sel_valid_s1_o     = g_setup[0].ctl_pval_ff;
  assign sample_rate_code_s1_o   = g_setup[0].ctl_rate_ff;
  assign rate_code_valid_s1_o    = g_setup[0].ctl_rval_ff;
  assign direct_decim_mode_s2_o  = g_setup[1].ctl_map_ff;
  assign direct_decim_value_s2_o = g_setup[1].ctl_decim_ff;
  assign decim_total_s2_o        = g_setup[1].ctl_total_ff;
  assign filter_type_s2_o        = g_setup[1].ctl_type_ff;
  assign post_rejection_on_s2_o  = g_setup[1].ctl_pon_ff;
  assign post_rejection_sel_s2_o = g_setup[1].ctl_psel_ff;
  assign post_sel_valid_s2_o     = g_setup[1].ctl_pval_ff;
  assign sample_rate_code_s2_o   = g_setup[1].ctl_rate_ff;
  assign rate_code_valid_s2_o    = g_setup[1].ctl_rval_ff;

endmodule

/* filt_cfg_sva.sv */
// Assertion checker for the setup filter register bank
// Assumes binding onto the bank and its single clock domain
`timescale 1ns/1ps
`include "filt_setup_map.vh"
module filt_cfg_sva
(
  // Clock and reset
  input wire        sys_clk_i,
  input wire        nrst_i,
  // Bus handshakes
  input wire        s_axi_arvalid_i,
  input wire        s_axi_arready_o,
  input wire        s_axi_rvalid_o,
  input wire        s_axi_rready_i,
  input wire [31:0] s_axi_rdata_o,
  input wire        s_axi_bvalid_o,
  input wire        s_axi_bready_i,
  input wire [1:0]  s_axi_bresp_o,
  // Setup 1 controls
  input wire        direct_decim_mode_s1_o,
  input wire [14:0] direct_decim_value_s1_o,
  input wire [20:0] decim_total_s1_o,
  input wire [1:0]  filter_type_s1_o,
  input wire        post_rejection_on_s1_o,
  input wire [2:0]  post_rejection_sel_s1_o,
  input wire        post_sel_valid_s1_o,
  input wire [4:0]  sample_rate_code_s1_o,
  input wire        rate_code_valid_s1_o
);
  // --------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  // Map mode overrides all other options
  property p_map;
    direct_decim_mode_s1_o |-> filter_type_s1_o == `FTYPE_SINC3
      && sample_rate_code_s1_o == 5'h0 && !post_rejection_on_s1_o;
  endproperty
  a_map: assert property (p_map) else $error("map mode leaks options");
  property p_nomap;
    !direct_decim_mode_s1_o |-> direct_decim_value_s1_o == 15'h0;
  endproperty
  a_nomap: assert property (p_nomap) else $error("decim value outside map");
  property p_total;
    decim_total_s1_o == {1'b0, direct_decim_value_s1_o, 5'h0};
  endproperty
  a_total: assert property (p_total) else $error("decim total not 32x");
  // Post filter only behind sinc5+sinc1 and a listed code
  property p_post;
    post_rejection_on_s1_o |-> filter_type_s1_o == `FTYPE_SINC5_SINC1 && post_sel_valid_s1_o;
  endproperty
  a_post: assert property (p_post) else $error("post filter on wrongly");
  property p_sel;
    post_sel_valid_s1_o == (post_rejection_sel_s1_o inside {3'h2, 3'h3, 3'h5, 3'h6});
  endproperty
  a_sel: assert property (p_sel) else $error("post select decode wrong");
  property p_rate;
    !direct_decim_mode_s1_o |-> rate_code_valid_s1_o == (sample_rate_code_s1_o <= 5'h14);
  endproperty
  a_rate: assert property (p_rate) else $error("rate code range wrong");
  // Reserved bits belong to the decimation value only in map mode
  property p_resv;
    s_axi_rvalid_o |-> s_axi_rdata_o[31:16] == 16'h0 && (s_axi_rdata_o[15]
      || (s_axi_rdata_o[14:12] == 3'h0 && !s_axi_rdata_o[7]));
  endproperty
  a_resv: assert property (p_resv) else $error("reserved bits read nonzero");
  property p_rst;
    $rose(nrst_i) |-> filter_type_s1_o == 2'h0 && sample_rate_code_s1_o == 5'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("controls not zero after reset");
  // Read answer comes the cycle after the address is taken; answers hold until taken
  property p_rans;
    s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o;
  endproperty
  a_rans: assert property (p_rans) else $error("read answer late");
  property p_hold;
    s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o);
  endproperty
  a_hold: assert property (p_hold) else $error("read data dropped");
  property p_bhold;
    s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  c_wr: cover property (s_axi_bvalid_o && s_axi_bready_i);
  c_err: cover property (s_axi_bvalid_o && s_axi_bresp_o == `AXI_SLVERR);
  c_map: cover property ($rose(direct_decim_mode_s1_o));
endmodule

bind adc_filter_setup_config_regs filt_cfg_sva filt_cfg_sva_inst
(
  .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .s_axi_arvalid_i(s_axi_arvalid_i),
  .s_axi_arready_o(s_axi_arready_o), .s_axi_rvalid_o(s_axi_rvalid_o),
  .s_axi_rready_i(s_axi_rready_i), .s_axi_rdata_o(s_axi_rdata_o),
  .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
  .s_axi_bresp_o(s_axi_bresp_o), .direct_decim_mode_s1_o(direct_decim_mode_s1_o),
  .direct_decim_value_s1_o(direct_decim_value_s1_o), .decim_total_s1_o(decim_total_s1_o),
  .filter_type_s1_o(filter_type_s1_o), .post_rejection_on_s1_o(post_rejection_on_s1_o),
  .post_rejection_sel_s1_o(post_rejection_sel_s1_o), .post_sel_valid_s1_o(post_sel_valid_s1_o),
  .sample_rate_code_s1_o(sample_rate_code_s1_o), .rate_code_valid_s1_o(rate_code_valid_s1_o)
);

/* testbench.sv */
// Self-checking bench for the setup filter register bank
// Assumes the bank answers AXI4-Lite on one 125 MHz clock
`timescale 1ns/1ps
`include "filt_setup_map.vh"
module testbench;
  reg         sys_clk_i, nrst_i, awvalid, wvalid, bready, arvalid, rready;
  reg  [9:0]  awaddr, araddr;
  reg  [31:0] wdata, seed, wd;
  wire [20:0] tot1, tot2;
  wire [2:0]  ps1, ps2;
  wire        pon1, pon2, pv1, pv2, rv1, rv2;
  reg  [3:0]  wstrb;
  reg  [15:0] m1, m2;
  reg  [33:0] q[$];
  wire        awready, wready, bvalid, arready, rvalid, mode1, mode2;
  wire [1:0]  bresp, rresp, type1, type2;
  wire [31:0] rdata;
  wire [4:0]  rate1, rate2;
  wire [14:0] val1, val2;
  integer     errors, samples_checked, i;

  adc_filter_setup_config_regs adc_filter_setup_config_regs_inst
  (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .direct_decim_mode_s1_o(mode1),
    .direct_decim_value_s1_o(val1), .decim_total_s1_o(tot1), .filter_type_s1_o(type1),
    .post_rejection_on_s1_o(pon1), .post_rejection_sel_s1_o(ps1), .post_sel_valid_s1_o(pv1),
    .sample_rate_code_s1_o(rate1), .rate_code_valid_s1_o(rv1),
    .direct_decim_mode_s2_o(mode2), .direct_decim_value_s2_o(val2), .decim_total_s2_o(tot2),
    .filter_type_s2_o(type2), .post_rejection_on_s2_o(pon2), .post_rejection_sel_s2_o(ps2),
    .post_sel_valid_s2_o(pv2), .sample_rate_code_s2_o(rate2), .rate_code_valid_s2_o(rv2)
  );

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  function [31:0] xs(input [31:0] x);
    reg [31:0] y;
    begin
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      xs = y ^ (y << 5);
    end
  endfunction
  // Byte lanes 0 and 1 only; reserved bits stored only in map mode
  function [15:0] upd(input [15:0] r, input [31:0] d, input [3:0] s);
    reg [15:0] bm;
    begin
      bm = {{8{s[1]}}, {8{s[0]}}};
      upd = (r & ~bm) | (d[15:0] & bm);
      if (!upd[15])
        upd = upd & `FCFG_WR_MASK;
    end
  endfunction
  // Expected {total, post on, post select, select listed, rate listed}
  function [33:0] dx(input [15:0] v);
    reg ok;
    begin
      ok = v[10:8] == `PSEL_27SPS || v[10:8] == `PSEL_25SPS ||
           v[10:8] == `PSEL_20SPS || v[10:8] == `PSEL_16SPS;
      if (v[15])
        dx = {8'h0, v[14:0], 5'h0, 6'h01};
      else
        dx = {28'h0, v[11] && v[6:5] == `FTYPE_SINC5_SINC1 && ok, v[10:8], ok,
              v[4:0] <= `RATE_CODE_MAX};
    end
  endfunction
  // Expected {mode, type, rate, value} of one setup
  function [33:0] dp(input [15:0] v);
    dp = v[15] ? {11'h0, 1'b1, `FTYPE_SINC3, 5'h0, v[14:0]} : {12'h0, v[6:0], 15'h0};
  endfunction
  task chk(input [33:0] g, input [33:0] e);
    begin
      samples_checked = samples_checked + 1;
      if (g !== e)
      begin
        errors = errors + 1;
        $display("unexpected at %0t: got %h, expected %h", $time, g, e);
      end
    end
  endtask
  task conclude;
    begin
      $display("checked %0d, errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task tmo(input integer n);
    if (n >= 40)
    begin
      errors = errors + 1;
      conclude;
    end
  endtask
  // Write; ready for the answer is raised late on some runs
  task wr(input [9:0] a, input [31:0] d, input [3:0] s, input [33:0] e);
    integer n;
    begin
      @(posedge sys_clk_i);
      q.push_back(e);
      {awaddr, wdata, wstrb, awvalid, wvalid, bready} <= {a, d, s, 2'b11, seed[3]};
      n = 0;
      do
      begin
        @(posedge sys_clk_i);
        n = n + 1;
        if (awready)
          awvalid <= 1'b0;
        if (wready)
          wvalid <= 1'b0;
        bready <= !(bvalid && bready);
      end
      while (!(bvalid && bready) && n < 40);
      tmo(n);
    end
  endtask
  task rd(input [9:0] a, input [33:0] e);
    integer n;
    begin
      @(posedge sys_clk_i);
      q.push_back(e);
      {araddr, arvalid, rready} <= {a, 1'b1, seed[4]};
      n = 0;
      do
      begin
        @(posedge sys_clk_i);
        n = n + 1;
        if (arready)
          arvalid <= 1'b0;
        rready <= !(rvalid && rready);
      end
      while (!(rvalid && rready) && n < 40);
      tmo(n);
    end
  endtask

  // Clock
  initial
  begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end
  // Answers compared against the oldest note
  always @(posedge sys_clk_i)
    if ((bvalid && bready) || (rvalid && rready))
      chk(bvalid ? {bresp, 32'h0} : {rresp, rdata}, q.pop_front());

  // Main sequence
  initial
  begin
    {nrst_i, awaddr, araddr, wdata, wstrb, awvalid, wvalid, bready, arvalid, rready} = 0;
    {errors, samples_checked, m1, m2} = 0;
    seed = 32'd18;
    repeat (5) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    rd(`FCFG_ADDR_S1, {`AXI_OKAY, 32'h0});
    rd(`FCFG_ADDR_S2, {`AXI_OKAY, 32'h0});
    wr(10'h0ac, 32'hffff, 4'hf, {`AXI_SLVERR, 32'h0});
    rd(10'h0ac, {`AXI_SLVERR, 32'h0});
    // Random contents, reserved bits set too, through both setups
    for (i = 0; i < 60; i = i + 1)
    begin
      seed = xs(seed);
      wd = seed;
      // Host keeps to listed post codes and reserved zeros outside map mode
      wd[10:8] = seed[12] ? (seed[11] ? `PSEL_16SPS : `PSEL_20SPS) :
                 (seed[11] ? `PSEL_25SPS : `PSEL_27SPS);
      if (!wd[15])
        wd = wd & {16'h0, `FCFG_WR_MASK};
      if (!wd[15] && wd[6:5] == `FTYPE_SINC3)
        wd[4:0] = 5'h0a;
      if (seed[5])
        m2 = upd(m2, wd, seed[9:6]);
      else
        m1 = upd(m1, wd, seed[9:6]);
      wr(seed[5] ? `FCFG_ADDR_S2 : `FCFG_ADDR_S1, wd, seed[9:6], {`AXI_OKAY, 32'h0});
      rd(`FCFG_ADDR_S1, {`AXI_OKAY, 16'h0, m1});
      rd(`FCFG_ADDR_S2, {`AXI_OKAY, 16'h0, m2});
      chk({11'h0, mode1, type1, rate1, val1}, dp(m1));
      chk({11'h0, mode2, type2, rate2, val2}, dp(m2));
      chk({7'h0, tot1, pon1, ps1, pv1, rv1}, dx(m1));
      chk({7'h0, tot2, pon2, ps2, pv2, rv2}, dx(m2));
    end
    // Reset in mid-run clears both setups
    @(posedge sys_clk_i);
    nrst_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    rd(`FCFG_ADDR_S1, {`AXI_OKAY, 32'h0});
    chk({11'h0, mode2, type2, rate2, val2}, 34'h0);
    chk({7'h0, tot1, pon1, ps1, pv1, rv1}, dx(16'h0000));
    conclude;
  end
endmodule
